// ---- rtl/chd_pkg.sv ----
// Purpose: constants and carriers for the host data port and DMA handshake
// Assumes: one core clock, host strobes synchronised inside the block
// Notes: no registers reachable by software
// What this block does
// - sixteen data lines, low line even byte
// - register set byte-wide, data sixteen-bit
// - input ack asserted on selected I/O reads
// - memory mode ignores read strobe, ack
// - I/O mode read strobe gates data out
// - request raised when device ready to move
// - request held until ack, then reraise
// - request undriven unless device selected
// - three low address lines pick register
package chd_pkg;
  localparam int DATA_W = 16;
  localparam int BYTE_W = 8;
  localparam int ADDR_W = 3;
  localparam int SYNC_W = 2;
  localparam logic [BYTE_W-1:0] BYTE_ZERO = 8'h00;

  typedef enum logic [1:0] {
    CHD_MODE_MEMORY,
    CHD_MODE_IO,
    CHD_MODE_IDE
  } chd_mode_t;

  typedef enum logic [1:0] {
    CHD_DMA_IDLE,
    CHD_DMA_REQ,
    CHD_DMA_ACKED
  } chd_dma_state_t;

  // synchronised host strobes
  typedef struct packed {
    logic rd_n;
    logic wr_n;
    logic cs_low_n;
    logic cs_high_n;
    logic dma_ack_n_n;
  } chd_strobes_t;

  // drive set toward the host pins
  typedef struct packed {
    logic [DATA_W-1:0] data;
    logic data_oe;
    logic input_ack_n;
    logic dma_request;
    logic dma_request_oe;
  } chd_pins_t;
endpackage : chd_pkg

// ---- rtl/chd_sync.sv ----
// Purpose: two-stage synchroniser for a group of host strobes
// Assumes: inputs come from pins outside the core clock domain
// Notes: first stage is read only by the second stage
`timescale 1ns/10ps
module chd_sync (
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input chd_pkg::chd_strobes_t i_async,
  output chd_pkg::chd_strobes_t o_sync
);
  import chd_pkg::*;

  typedef struct packed {
    chd_strobes_t s1;
    chd_strobes_t s2;
  } chd_sync_state_t;

  // inactive strobes are all high
  localparam chd_strobes_t IDLE = '{rd_n: 1'b1, wr_n: 1'b1, cs_low_n: 1'b1,
                                    cs_high_n: 1'b1, dma_ack_n_n: 1'b1};

  chd_sync_state_t st;
  chd_sync_state_t next_st;

  always_comb begin
    next_st.s1 = i_async;
    next_st.s2 = st.s1;
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st <= '{s1: IDLE, s2: IDLE};
    end else begin
      st <= next_st;
    end
  end

  assign o_sync = st.s2;
endmodule : chd_sync

// ---- rtl/chd_host_port.sv ----
// Purpose: host data lanes, input acknowledge, I/O read gating, DMA handshake
// Assumes: mode and select come from configuration logic on the core clock
// Notes: pins are split into in, out and enable; strobes synchronised first
`timescale 1ns/10ps
module chd_host_port (
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input chd_pkg::chd_mode_t i_mode,
  input wire logic i_device_selected,
  input wire logic i_addr_match,
  input wire logic [chd_pkg::ADDR_W-1:0] i_host_addr,
  input wire logic i_reg_access,
  input wire logic [chd_pkg::DATA_W-1:0] i_read_data,
  input wire logic i_dma_ready,
  input wire logic i_io_read_strobe_n,
  input wire logic i_io_write_strobe_n,
  input wire logic i_chip_select_low_n,
  input wire logic i_chip_select_high_n,
  input wire logic i_dma_ack_n,
  input wire logic [chd_pkg::DATA_W-1:0] i_host_data_lines,
  output logic [chd_pkg::DATA_W-1:0] o_host_data_lines,
  output logic o_host_data_lines_oe,
  output logic o_input_ack_n,
  output logic o_dma_request,
  output logic o_dma_request_oe,
  output logic [chd_pkg::DATA_W-1:0] o_write_data,
  output logic o_write_valid,
  output logic o_dma_word_done,
  output logic [chd_pkg::ADDR_W-1:0] o_reg_index
);
  import chd_pkg::*;

  typedef struct packed {
    chd_pins_t pins;
    chd_dma_state_t dma;
    logic wr_n_q;
    logic rd_n_q;
    logic [DATA_W-1:0] wdata;
    logic wvalid;
    logic word_done;
    logic [ADDR_W-1:0] reg_index;
    logic [DATA_W-1:0] hd_s1;
    logic [DATA_W-1:0] hd_s2;
    logic [ADDR_W-1:0] ad_s1;
    logic [ADDR_W-1:0] ad_s2;
  } chd_port_state_t;

  chd_strobes_t raw;
  chd_strobes_t syn;
  chd_port_state_t st;
  chd_port_state_t next_st;
  logic rd_active;
  logic dma_cycle;
  logic io_read;
  logic ide_read;

  assign raw = '{rd_n: i_io_read_strobe_n, wr_n: i_io_write_strobe_n,
                 cs_low_n: i_chip_select_low_n, cs_high_n: i_chip_select_high_n,
                 dma_ack_n_n: i_dma_ack_n};

  chd_sync u_sync (
    .i_core_clk(i_core_clk),
    .i_rst_n(i_rst_n),
    .i_async(raw),
    .o_sync(syn)
  );

  always_comb begin
    rd_active = !syn.rd_n;
    // DMA cycle: ack low with both chip selects negated
    dma_cycle = (i_mode == CHD_MODE_IDE) && !syn.dma_ack_n_n
                && syn.cs_low_n && syn.cs_high_n;
    // memory mode gives the read strobe no function
    io_read = (i_mode == CHD_MODE_IO) && rd_active
              && i_device_selected && i_addr_match;
    ide_read = (i_mode == CHD_MODE_IDE) && rd_active && i_device_selected
               && (dma_cycle || i_addr_match);

    next_st = st;
    next_st.rd_n_q = syn.rd_n;
    next_st.wr_n_q = syn.wr_n;
    next_st.wvalid = 1'b0;
    next_st.word_done = 1'b0;
    // host data and address lines cross two flops, in step with the strobes
    next_st.hd_s1 = i_host_data_lines;
    next_st.hd_s2 = st.hd_s1;
    next_st.ad_s1 = i_host_addr;
    next_st.ad_s2 = st.ad_s1;
    next_st.reg_index = st.ad_s2;

    // register set on the low byte, DMA words full width
    next_st.pins.data_oe = io_read || ide_read;
    if (i_reg_access && !dma_cycle) begin
      next_st.pins.data = {BYTE_ZERO, i_read_data[BYTE_W-1:0]};
    end else begin
      next_st.pins.data = i_read_data;
    end

    // memory mode leaves input ack high
    next_st.pins.input_ack_n = !io_read;

    // write data taken on rising edge of write strobe
    if (syn.wr_n && !st.wr_n_q && i_device_selected
        && (i_mode != CHD_MODE_MEMORY)) begin
      next_st.wvalid = 1'b1;
      if (i_reg_access && !dma_cycle) begin
        next_st.wdata = {BYTE_ZERO, st.hd_s2[BYTE_W-1:0]};
      end else begin
        next_st.wdata = st.hd_s2;
      end
    end

    // multiword handshake: request, acknowledge, strobes, release
    unique case (st.dma)
      CHD_DMA_IDLE: begin
        if (i_mode == CHD_MODE_IDE && i_dma_ready) begin
          next_st.dma = CHD_DMA_REQ;
        end
      end
      CHD_DMA_REQ: begin
        if (dma_cycle) begin
          next_st.dma = CHD_DMA_ACKED;
        end
      end
      CHD_DMA_ACKED: begin
        if ((syn.rd_n && !st.rd_n_q) || (syn.wr_n && !st.wr_n_q)) begin
          next_st.word_done = 1'b1;
        end
        if (syn.dma_ack_n_n) begin
          next_st.dma = i_dma_ready ? CHD_DMA_REQ : CHD_DMA_IDLE;
        end
      end
      default: next_st.dma = CHD_DMA_IDLE;
    endcase
    next_st.pins.dma_request = (next_st.dma == CHD_DMA_REQ);
    next_st.pins.dma_request_oe = i_device_selected
                                  && (i_mode == CHD_MODE_IDE);
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st <= '0;
      st.pins.input_ack_n <= 1'b1;
      st.rd_n_q <= 1'b1;
      st.wr_n_q <= 1'b1;
      st.dma <= CHD_DMA_IDLE;
    end else begin
      st <= next_st;
    end
  end

  // pins and pulses come straight from the state flops
  assign o_host_data_lines = st.pins.data;
  assign o_host_data_lines_oe = st.pins.data_oe;
  assign o_input_ack_n = st.pins.input_ack_n;
  assign o_dma_request = st.pins.dma_request;
  assign o_dma_request_oe = st.pins.dma_request_oe;
  assign o_write_data = st.wdata;
  assign o_write_valid = st.wvalid;
  assign o_dma_word_done = st.word_done;
  assign o_reg_index = st.reg_index;

  default clocking cb_core @(posedge i_core_clk);
  endclocking
  default disable iff (!i_rst_n);

  // request stays up until an acknowledge is seen
  sequence s_req_up;
    st.dma == CHD_DMA_REQ;
  endsequence
  sequence s_acked;
    st.dma == CHD_DMA_ACKED;
  endsequence
  // acknowledge still low after the synchroniser
  sequence s_ack_held;
    !syn.dma_ack_n_n;
  endsequence

  a_req_holds_until_ack: assert property (
    (s_req_up and !dma_cycle) |=> s_req_up)
    else $error("dma request dropped before acknowledge");
  a_ack_moves_state: assert property (
    (s_req_up and dma_cycle) |=> s_acked)
    else $error("acknowledge not taken");
  a_req_pin_follows: assert property (
    s_req_up |-> o_dma_request)
    else $error("request pin low while requesting");
  a_ready_raises_req: assert property (
    (st.dma == CHD_DMA_IDLE && i_mode == CHD_MODE_IDE && i_dma_ready) |=> o_dma_request)
    else $error("ready did not raise request");
  a_acked_holds: assert property (
    (s_acked and s_ack_held) |=> s_acked)
    else $error("acknowledged state left while ack low");
  a_req_low_acked: assert property (
    s_acked |-> !o_dma_request)
    else $error("request still high after acknowledge");
  a_word_done_acked: assert property (
    o_dma_word_done |-> $past(st.dma) == CHD_DMA_ACKED)
    else $error("dma word counted outside acknowledge");
  a_req_oe_select: assert property (
    !i_device_selected |=> !o_dma_request_oe)
    else $error("request driven while not selected");

  a_ack_io_read: assert property (
    io_read |=> !o_input_ack_n && o_host_data_lines_oe)
    else $error("input ack missing on io read");
  a_ack_only_io: assert property (
    !o_input_ack_n |-> $past(i_mode) == CHD_MODE_IO)
    else $error("input ack outside io mode");
  a_mem_mode_quiet: assert property (
    (i_mode == CHD_MODE_MEMORY) |=> o_input_ack_n && !o_host_data_lines_oe)
    else $error("memory mode used read strobe");
  a_data_oe_idle: assert property (
    syn.rd_n |=> !o_host_data_lines_oe)
    else $error("data bus driven without read");
  a_data_oe_sel: assert property (
    o_host_data_lines_oe |-> $past(i_device_selected))
    else $error("data bus driven while not selected");

  a_reg_byte_lane: assert property (
    (i_reg_access && !dma_cycle) |=> o_host_data_lines[DATA_W-1:BYTE_W] == BYTE_ZERO)
    else $error("register read used high byte");
  a_dma_full_word: assert property (
    dma_cycle |=> o_host_data_lines == $past(i_read_data))
    else $error("dma read word not full width");
endmodule : chd_host_port

// ---- test/chd_host_model.sv ----
// Purpose: host adapter model answering the DMA request
// Assumes: changes ack just after the rising edge
// Notes: i_slow delays the acknowledge
`timescale 1ns/10ps
module chd_host_model (
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic i_req,
  input wire logic i_req_oe,
  input wire logic i_slow,
  output logic o_dma_ack_n
);
  int cnt;
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_dma_ack_n <= 1'b1;
      cnt <= 0;
    end else if (o_dma_ack_n) begin
      // ack only a driven request
      if (i_req && i_req_oe) begin
        cnt <= cnt + 1;
        if (cnt >= (i_slow ? 8 : 1)) begin
          o_dma_ack_n <= 1'b0;
          cnt <= 0;
        end
      end else begin
        cnt <= 0;
      end
    end else begin
      cnt <= cnt + 1;
      // ack held long enough for one strobe pulse
      if (cnt >= 12) begin
        o_dma_ack_n <= 1'b1;
        cnt <= 0;
      end
    end
  end
endmodule : chd_host_model

// ---- test/tb.sv ----
// Purpose: random and corner tests of the host port
// Assumes: inputs change on the falling edge
// Notes: chip selects held negated, DMA words 16 bit
`timescale 1ns/10ps
module tb;
  import chd_pkg::*;
  logic clk = 0, rst_n = 0, sel = 0, am = 0, rga = 0, rdy = 0, slow = 0;
  logic rd_n = 1, wr_n = 1, cs_n = 1, doe, iack_n, req, req_oe, wv, ack_n, wd;
  chd_mode_t mode = CHD_MODE_MEMORY;
  logic [2:0] addr = 3'h0, ridx;
  logic [15:0] rdat = 16'h0000, hdat = 16'h0000, dout, wdat, exp;
  int err_total = 0, n_compared = 0, k;
  always #5 clk = ~clk;
  chd_host_port i_dut (.i_core_clk(clk), .i_rst_n(rst_n), .i_mode(mode),
    .i_device_selected(sel), .i_addr_match(am), .i_host_addr(addr),
    .i_reg_access(rga), .i_read_data(rdat), .i_dma_ready(rdy),
    .i_io_read_strobe_n(rd_n), .i_io_write_strobe_n(wr_n),
    .i_chip_select_low_n(cs_n), .i_chip_select_high_n(cs_n),
    .i_dma_ack_n(ack_n), .i_host_data_lines(hdat), .o_host_data_lines(dout),
    .o_host_data_lines_oe(doe), .o_input_ack_n(iack_n), .o_dma_request(req),
    .o_dma_request_oe(req_oe), .o_write_data(wdat), .o_write_valid(wv),
    .o_dma_word_done(wd), .o_reg_index(ridx));
  chd_host_model i_host (.i_core_clk(clk), .i_rst_n(rst_n), .i_req(req),
    .i_req_oe(req_oe), .i_slow(slow), .o_dma_ack_n(ack_n));
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    n_compared++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  function automatic logic [15:0] exp_rd(input logic byte_reg, input logic [15:0] d);
    return byte_reg ? {8'h00, d[7:0]} : d;
  endfunction : exp_rd
  task automatic print_verdict;
    $display("compared %0d errors %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : print_verdict
  initial begin
    #100000;
    err_total++;
    print_verdict();
  end
  initial begin
    void'($urandom(55));
    cyc(3);
    chk({doe, iack_n, req, req_oe}, 4'h4);
    rst_n = 1;
    for (k = 0; k < 15; k++) begin
      mode = chd_mode_t'(k % 3);
      sel = (k == 1) ? 1'b1 : 1'($urandom);
      am = (mode == CHD_MODE_IDE || k == 1) ? 1'b1 : 1'($urandom);
      rga = (mode == CHD_MODE_IDE) ? 1'($urandom) : 1'b0;
      addr = $urandom;
      rdat = (k == 1) ? 16'hFFFF : $urandom;
      rd_n = 0;
      cyc(4);
      exp = exp_rd(rga, rdat);
      chk(ridx, addr);
      chk(doe, mode != CHD_MODE_MEMORY && sel && am);
      chk(iack_n, !(mode == CHD_MODE_IO && sel && am));
      if (iack_n === 1'b0) chk(doe, 1'b1);
      if (doe === 1'b1) chk(dout, exp);
      rd_n = 1;
      cyc(4);
      chk({doe, iack_n}, 2'h1);
    end
    mode = CHD_MODE_IO;
    rga = 0;
    sel = 1;
    am = 1;
    hdat = $urandom;
    wr_n = 0;
    cyc(4);
    wr_n = 1;
    for (k = 0; k < 8 && wv !== 1'b1; k++) cyc(1);
    chk(wv, 1'b1);
    chk(wdat, hdat);
    rga = 1;
    for (k = 0; k < 2; k++) begin
      slow = k;
      mode = CHD_MODE_IDE;
      rdy = 1;
      for (int j = 0; j < 10 && req !== 1'b1; j++) cyc(1);
      chk({req, req_oe}, 2'h3);
      cyc(6);
      if (slow) chk({req, ack_n}, 2'h3);
      for (int j = 0; j < 20 && req !== 1'b0; j++) cyc(1);
      chk({req, ack_n}, 2'h0);
      hdat = $urandom;
      if (slow) wr_n = 0;
      else rd_n = 0;
      cyc(3);
      chk(doe, !slow);
      if (!slow) chk(dout, rdat);
      rd_n = 1;
      wr_n = 1;
      for (int j = 0; j < 8 && wd !== 1'b1; j++) cyc(1);
      chk(wd, 1'b1);
      chk(wv, slow);
      if (slow) chk(wdat, hdat);
      for (int j = 0; j < 30 && req !== 1'b1; j++) cyc(1);
      chk(req, 1'b1);
      rdy = 0;
      cyc(12);
    end
    sel = 0;
    cyc(3);
    chk(req_oe, 1'b0);
    print_verdict();
  end
endmodule : tb
